// ===== src/arb_consts.svh
// Purpose : Offsets, reset values, masks and command codes of the register bank
// Assumes : Byte-wide registers, one register moved per command
// Notes   : Included by every design file that needs a number
//
// Overview of operation
// - Nineteen byte registers hold configuration and status.
// - One register byte moves per read/write command.
// - 00h-0Fh need converter select; 10h-12h amplifier select.
// - Changing rate, conversion or reference restarts conversion.
// - Identity register read-only: part code, revision.
// - Status bit 7 shows converter block write lock.
// - Status bit 6 latches converter CRC error; write-0 clears.
// - Amplifier lock and CRC error live in amplifier status.
// - Status bit 4 ORs all amplifier-side logged errors.
// - Status bit 3 flags low reference, refreshed each cycle.
// - Status bit 2 marks result new since read.
// - Status bit 1 shows external conversion clock in use.
// - Reset sets status bit 0; write 0 clears.
// - Reads outside implemented range return zero.
// - Locked block ignores writes but serves reads.
// - Read opcode 20h+address; write opcode 40h+address.
`ifndef ARB_CONSTS_SVH
`define ARB_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ARB_ADDR_ID         5'h00
`define ARB_ADDR_STATUS     5'h01
`define ARB_ADDR_RATE       5'h02
`define ARB_ADDR_CONV       5'h03
`define ARB_ADDR_GPIO       5'h04
`define ARB_ADDR_GPIOLVL    5'h05
`define ARB_ADDR_REF        5'h06
`define ARB_ADDR_OFC0       5'h07
`define ARB_ADDR_OFC1       5'h08
`define ARB_ADDR_OFC2       5'h09
`define ARB_ADDR_GAIN0      5'h0A
`define ARB_ADDR_GAIN1      5'h0B
`define ARB_ADDR_GAIN2      5'h0C
`define ARB_ADDR_IMUX       5'h0D
`define ARB_ADDR_IMAG       5'h0E
`define ARB_ADDR_RSVD       5'h0F
`define ARB_ADDR_AMPGAIN    5'h10
`define ARB_ADDR_ALARM      5'h11
`define ARB_ADDR_AMPBLK     5'h12

// ----------------------------------------------------------------
// Reset values and writable-bit masks
// ----------------------------------------------------------------
`define ARB_RST_RATE        8'h24
`define ARB_RST_CONV        8'h01
`define ARB_RST_REF         8'h05
`define ARB_RST_GAIN2       8'h40
`define ARB_RST_IMUX        8'hFF
`define ARB_RST_AMPGAIN     8'h50
`define ARB_MASK_CONV       8'h3F
`define ARB_MASK_GPIOLVL    8'h4F
`define ARB_MASK_REF        8'h1F
`define ARB_MASK_AMPGAIN    8'h7F
`define ARB_MASK_ALL        8'hFF

// ----------------------------------------------------------------
// Field positions and command codes
// ----------------------------------------------------------------
`define ARB_ST_CRC_BIT      3'd6
`define ARB_ST_RESET_BIT    3'd0
`define ARB_BLK_CRC_BIT     3'd4
`define ARB_OP_GROUP_MASK   8'hE0
`define ARB_OP_READ         8'h20
`define ARB_OP_WRITE        8'h40
`define ARB_OP_LOCK         8'hF2
`define ARB_OP_UNLOCK       8'hF5
`define ARB_OP_RESET        8'h06

`endif

// ===== src/arb_pkg.sv
// Purpose : Types shared by the register bank modules
// Assumes : Constants live in arb_consts.svh
// Notes   : Whole module state is one packed struct
package arb_pkg;

  typedef enum logic [2:0]
  {
    PH_IDLE  = 3'b001,
    PH_EXEC  = 3'b010,
    PH_REPLY = 3'b100
  } arb_phase_t;

  typedef struct packed {
    arb_phase_t       phase;
    logic [7:0]       opcode;
    logic [7:0]       wdata;
    logic             crcBad;
    logic             onConv;
    logic             onAmp;
    logic [18:0][7:0] regs;
    logic             convLock;
    logic             ampLock;
    logic             crcConv;
    logic             crcAmp;
    logic             resetSeen;
    logic             newResult;
    logic             refLow;
    logic             restart;
    logic [7:0]       rspData;
  } arb_state_t;

endpackage : arb_pkg

// ===== src/arb_sync2.sv
// Purpose : Two-stage synchroniser for pin levels
// Assumes : Inputs are slow levels, not pulses
// Notes   : First stage feeds only the second stage
`timescale 1ns/1ps
module arb_sync2 #(
  parameter int               WIDTH       = 2,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } arb_sync_state_t;

  arb_sync_state_t syncState_reg;
  arb_sync_state_t syncState_next;

  always_comb
  begin
    syncState_next        = syncState_reg;
    syncState_next.stage1 = asyncIn;
    syncState_next.stage2 = syncState_reg.stage1;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      syncState_reg <= '{stage1: RESET_VALUE, stage2: RESET_VALUE};
    else
      syncState_reg <= syncState_next;
  end

  assign syncOut = syncState_reg.stage2;

endmodule : arb_sync2

// ===== src/arb_sticky_flags.sv
// Purpose : Per-bit sticky event flags
// Assumes : Set and clear are one-cycle pulses or levels on clk
// Notes   : A set in the clearing cycle wins, so no event is lost
`timescale 1ns/1ps
module arb_sticky_flags #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Events and clears
  input  wire logic [WIDTH-1:0] setIn,
  input  wire logic [WIDTH-1:0] clearIn,
  output logic      [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } arb_sticky_state_t;

  arb_sticky_state_t stickyState_reg;
  arb_sticky_state_t stickyState_next;
  logic [WIDTH-1:0]  bitNext;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      assign bitNext[i] = setIn[i] | (stickyState_reg.flags[i] & ~clearIn[i]);
    end
  endgenerate

  always_comb
  begin
    stickyState_next       = stickyState_reg;
    stickyState_next.flags = bitNext;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      stickyState_reg <= '0;
    else
      stickyState_reg <= stickyState_next;
  end

  assign flags = stickyState_reg.flags;

endmodule : arb_sticky_flags

// ===== src/arb_register_bank.sv
// Purpose : Register bank of a delta-sigma converter with a gain amplifier
// Assumes : A serial front end hands over one checked command at a time
// Notes   : Two chip selects split the map into converter and amplifier blocks
`timescale 1ns/1ps
`include "arb_consts.svh"
module arb_register_bank #(
  parameter logic [3:0] PART_CODE = 4'h5, // Arbitrary value
  parameter logic [3:0] REV_LOW   = 4'h1, // Arbitrary value
  parameter logic [3:0] REV_HIGH  = 4'h2  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Chip select pins, active low
  input  wire logic        converterSelectN,
  input  wire logic        amplifierSelectN,
  // Command from the serial front end
  input  wire logic        cmdValid,
  output logic             cmdReady,
  input  wire logic [7:0]  cmdOpcode,
  input  wire logic [7:0]  cmdData,
  input  wire logic        cmdCrcError,
  // Answer to the serial front end
  output logic             rspValid,
  output logic [7:0]       rspData,
  // Converter and monitor events
  input  wire logic        resultReady,
  input  wire logic        resultRead,
  input  wire logic        cycleStart,
  input  wire logic        referenceLow,
  input  wire logic        externalClock,
  input  wire logic [7:0]  ampAlarm,
  // Configuration to the converter and amplifier
  output logic [7:0]       rateFilterConfig,
  output logic [7:0]       conversionConfig,
  output logic [7:0]       gpioSetup,
  output logic [7:0]       gpioLevelStatusEnable,
  output logic [7:0]       referenceConfig,
  output logic [23:0]      offsetCal,
  output logic [23:0]      gainCal,
  output logic [7:0]       excitationRoute,
  output logic [7:0]       excitationLevel,
  output logic [7:0]       ampInputGainConfig,
  // Status to the rest of the device
  output logic             conversionRestart,
  output logic             converterLockFlag,
  output logic             amplifierLockFlag,
  output logic             aggregateErrorFlag
);

  // ----------------------------------------------------------------
  // Reset image
  // ----------------------------------------------------------------
  function automatic arb_pkg::arb_state_t resetState();
    arb_pkg::arb_state_t st;
    st                         = '0;
    st.phase                   = arb_pkg::PH_IDLE;
    st.regs[`ARB_ADDR_RATE]    = `ARB_RST_RATE;
    st.regs[`ARB_ADDR_CONV]    = `ARB_RST_CONV;
    st.regs[`ARB_ADDR_REF]     = `ARB_RST_REF;
    st.regs[`ARB_ADDR_GAIN2]   = `ARB_RST_GAIN2;
    st.regs[`ARB_ADDR_IMUX]    = `ARB_RST_IMUX;
    st.regs[`ARB_ADDR_AMPGAIN] = `ARB_RST_AMPGAIN;
    st.resetSeen               = 1'b1;
    return st;
  endfunction : resetState

  localparam arb_pkg::arb_state_t RESET_STATE = resetState();

  // Reserved bits never take a written one
  function automatic logic [7:0] writeMask(input logic [4:0] addr);
    case (addr)
      `ARB_ADDR_CONV:    writeMask = `ARB_MASK_CONV;
      `ARB_ADDR_GPIOLVL: writeMask = `ARB_MASK_GPIOLVL;
      `ARB_ADDR_REF:     writeMask = `ARB_MASK_REF;
      `ARB_ADDR_AMPGAIN: writeMask = `ARB_MASK_AMPGAIN;
      default:           writeMask = `ARB_MASK_ALL;
    endcase
  endfunction : writeMask

  arb_pkg::arb_state_t s_reg;
  arb_pkg::arb_state_t s_next;
  logic [1:0]          selSync;
  logic [7:0]          alarmFlags;
  logic                alarmClear;
  logic [7:0]          mainStatus;
  logic [7:0]          rdVal;
  logic [4:0]          addr;
  logic                isRead;
  logic                isWrite;
  logic                inConv;
  logic                inAmp;

  // ----------------------------------------------------------------
  // Pin synchroniser and amplifier alarm log
  // ----------------------------------------------------------------
  arb_sync2 #(
    .WIDTH       (2),
    .RESET_VALUE (2'b11)
  ) u_selSync (
    .clk     (clk),
    .reset   (reset),
    .asyncIn ({amplifierSelectN, converterSelectN}),
    .syncOut (selSync)
  );

  // Alarms stay logged until the alarm register is read
  arb_sticky_flags #(
    .WIDTH (8)
  ) u_alarmLog (
    .clk     (clk),
    .reset   (reset),
    .setIn   (ampAlarm),
    .clearIn ({8{alarmClear}}),
    .flags   (alarmFlags)
  );

  // ----------------------------------------------------------------
  // Decode of the held command
  // ----------------------------------------------------------------
  assign addr    = s_reg.opcode[4:0];
  assign isRead  = (s_reg.opcode & `ARB_OP_GROUP_MASK) == `ARB_OP_READ;
  assign isWrite = (s_reg.opcode & `ARB_OP_GROUP_MASK) == `ARB_OP_WRITE;
  assign inConv  = s_reg.onConv && addr <= `ARB_ADDR_RSVD;
  assign inAmp   = s_reg.onAmp && addr >= `ARB_ADDR_AMPGAIN
                   && addr <= `ARB_ADDR_AMPBLK;

  assign aggregateErrorFlag = (|alarmFlags) | s_reg.crcAmp;
  assign mainStatus = {s_reg.convLock, s_reg.crcConv, 1'b0, aggregateErrorFlag,
                       s_reg.refLow, s_reg.newResult, externalClock,
                       s_reg.resetSeen};

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  always_comb
  begin
    case (addr)
      `ARB_ADDR_ID:     rdVal = {PART_CODE, REV_LOW};
      `ARB_ADDR_STATUS: rdVal = mainStatus;
      `ARB_ADDR_RSVD:   rdVal = 8'h00;
      `ARB_ADDR_ALARM:  rdVal = alarmFlags;
      `ARB_ADDR_AMPBLK: rdVal = {2'b00, s_reg.ampLock, s_reg.crcAmp, REV_HIGH};
      default:          rdVal = s_reg.regs[addr];
    endcase
  end

  // ----------------------------------------------------------------
  // Command sequencer and flags
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] wval;
    logic       setCrcConv;
    logic       setCrcAmp;
    logic       clrCrcConv;
    logic       clrCrcAmp;
    logic       clrReset;
    logic       setReset;
    wval       = 8'h00;
    setCrcConv = 1'b0;
    setCrcAmp  = 1'b0;
    clrCrcConv = 1'b0;
    clrCrcAmp  = 1'b0;
    clrReset   = 1'b0;
    setReset   = 1'b0;
    alarmClear = 1'b0;
    s_next         = s_reg;
    s_next.restart = 1'b0;
    case (s_reg.phase)
      arb_pkg::PH_IDLE:
      begin
        if (cmdValid)
        begin
          s_next.phase  = arb_pkg::PH_EXEC;
          s_next.opcode = cmdOpcode;
          s_next.wdata  = cmdData;
          s_next.crcBad = cmdCrcError;
          // Converter select wins if both are low
          s_next.onConv = !selSync[0];
          s_next.onAmp  = selSync[0] && !selSync[1];
        end
      end
      arb_pkg::PH_EXEC:
      begin
        s_next.phase   = arb_pkg::PH_REPLY;
        s_next.rspData = 8'h00;
        if (s_reg.crcBad)
        begin
          // A command that failed its check has no other effect
          setCrcConv = s_reg.onConv;
          setCrcAmp  = s_reg.onAmp;
        end
        else if (isRead && (inConv || inAmp))
        begin
          s_next.rspData = rdVal;
          alarmClear     = inAmp && addr == `ARB_ADDR_ALARM;
        end
        else if (isWrite && ((inConv && !s_reg.convLock) || (inAmp && !s_reg.ampLock)))
        begin
          wval = s_reg.wdata & writeMask(addr);
          case (addr)
            `ARB_ADDR_STATUS:
            begin
              clrCrcConv = !s_reg.wdata[`ARB_ST_CRC_BIT];
              clrReset   = !s_reg.wdata[`ARB_ST_RESET_BIT];
            end
            `ARB_ADDR_AMPBLK:
            begin
              clrCrcAmp = !s_reg.wdata[`ARB_BLK_CRC_BIT];
            end
            `ARB_ADDR_ID, `ARB_ADDR_RSVD, `ARB_ADDR_ALARM:
            begin
              wval = 8'h00;
            end
            default:
            begin
              s_next.regs[addr] = wval;
              if ((addr == `ARB_ADDR_RATE || addr == `ARB_ADDR_CONV
                   || addr == `ARB_ADDR_REF) && wval != s_reg.regs[addr])
                s_next.restart = 1'b1;
            end
          endcase
        end
        else if (s_reg.opcode == `ARB_OP_LOCK || s_reg.opcode == `ARB_OP_UNLOCK)
        begin
          if (s_reg.onConv)
            s_next.convLock = s_reg.opcode == `ARB_OP_LOCK;
          if (s_reg.onAmp)
            s_next.ampLock = s_reg.opcode == `ARB_OP_LOCK;
        end
        else if (s_reg.opcode == `ARB_OP_RESET && s_reg.onConv)
        begin
          // Command reset restores the register array, locks and CRC flags; alarm log, new-result and low-reference flags keep their state
          s_next.regs     = RESET_STATE.regs;
          s_next.convLock = 1'b0;
          s_next.ampLock  = 1'b0;
          s_next.restart  = 1'b1;
          clrCrcConv      = 1'b1;
          clrCrcAmp       = 1'b1;
          setReset        = 1'b1;
        end
      end
      arb_pkg::PH_REPLY:
      begin
        s_next.phase = arb_pkg::PH_IDLE;
      end
      default:
      begin
        s_next.phase = arb_pkg::PH_IDLE;
      end
    endcase
    // Every event flag lets its set win over a same-cycle clear
    s_next.crcConv   = setCrcConv | (s_reg.crcConv & ~clrCrcConv);
    s_next.crcAmp    = setCrcAmp | (s_reg.crcAmp & ~clrCrcAmp);
    s_next.resetSeen = setReset | (s_reg.resetSeen & ~clrReset);
    s_next.newResult = resultReady | (s_reg.newResult & ~resultRead);
    s_next.refLow    = referenceLow | (s_reg.refLow & ~cycleStart);
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      s_reg <= RESET_STATE;
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cmdReady              = s_reg.phase == arb_pkg::PH_IDLE;
  assign rspValid              = s_reg.phase == arb_pkg::PH_REPLY;
  assign rspData               = s_reg.rspData;
  assign conversionRestart     = s_reg.restart;
  assign converterLockFlag     = s_reg.convLock;
  assign amplifierLockFlag     = s_reg.ampLock;
  assign rateFilterConfig      = s_reg.regs[`ARB_ADDR_RATE];
  assign conversionConfig      = s_reg.regs[`ARB_ADDR_CONV];
  assign gpioSetup             = s_reg.regs[`ARB_ADDR_GPIO];
  assign gpioLevelStatusEnable = s_reg.regs[`ARB_ADDR_GPIOLVL];
  assign referenceConfig       = s_reg.regs[`ARB_ADDR_REF];
  assign offsetCal             = {s_reg.regs[`ARB_ADDR_OFC2], s_reg.regs[`ARB_ADDR_OFC1],
                                  s_reg.regs[`ARB_ADDR_OFC0]};
  assign gainCal               = {s_reg.regs[`ARB_ADDR_GAIN2], s_reg.regs[`ARB_ADDR_GAIN1],
                                  s_reg.regs[`ARB_ADDR_GAIN0]};
  assign excitationRoute       = s_reg.regs[`ARB_ADDR_IMUX];
  assign excitationLevel       = s_reg.regs[`ARB_ADDR_IMAG];
  assign ampInputGainConfig    = s_reg.regs[`ARB_ADDR_AMPGAIN];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_one_reply;
    (cmdValid && cmdReady) |=> !cmdReady
      ##1 (rspValid && !cmdReady) ##1 (!rspValid && cmdReady);
  endproperty
  a_one_reply: assert property (p_one_reply) else $error("reply not one pulse two cycles on");

  property p_wrong_select;
    (rspValid && isRead && s_reg.onAmp && addr <= `ARB_ADDR_RSVD) |-> rspData == 8'h00;
  endproperty
  a_wrong_select: assert property (p_wrong_select) else $error("converter reg seen on amp select");

  property p_restart;
    conversionRestart |-> $past(s_reg.phase) == arb_pkg::PH_EXEC
      && ($past(addr) inside {`ARB_ADDR_RATE, `ARB_ADDR_CONV, `ARB_ADDR_REF}
          || $past(s_reg.opcode) == `ARB_OP_RESET);
  endproperty
  a_restart: assert property (p_restart) else $error("restart without cause");

  property p_identity;
    (rspValid && s_reg.opcode == `ARB_OP_READ && s_reg.onConv && !s_reg.crcBad)
      |-> rspData == {PART_CODE, REV_LOW};
  endproperty
  a_identity: assert property (p_identity) else $error("identity read wrong");

  property p_lock_seen;
    (rspValid && s_reg.opcode == (`ARB_OP_READ | 8'h01) && s_reg.onConv && !s_reg.crcBad)
      |-> rspData[7] == converterLockFlag;
  endproperty
  a_lock_seen: assert property (p_lock_seen) else $error("lock bit misreported");

  property p_crc_hold;
    $fell(s_reg.crcConv) |-> $past(s_reg.phase) == arb_pkg::PH_EXEC
      && ($past(s_reg.opcode) == (`ARB_OP_WRITE | 8'h01)
          || $past(s_reg.opcode) == `ARB_OP_RESET);
  endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("crc flag cleared without write");

  property p_aggregate;
    (|ampAlarm) |=> aggregateErrorFlag;
  endproperty
  a_aggregate: assert property (p_aggregate) else $error("alarm not aggregated");

  property p_ref_refresh;
    (cycleStart && !referenceLow) |=> !s_reg.refLow;
  endproperty
  a_ref_refresh: assert property (p_ref_refresh) else $error("reference alarm not refreshed");

  property p_new_result;
    resultReady |=> s_reg.newResult;
  endproperty
  a_new_result: assert property (p_new_result) else $error("new result lost");

  property p_out_of_range;
    (rspValid && isRead && s_reg.onConv && addr > `ARB_ADDR_RSVD) |-> rspData == 8'h00;
  endproperty
  a_out_of_range: assert property (p_out_of_range) else $error("out of range read not zero");

  property p_locked_write;
    (s_reg.phase == arb_pkg::PH_EXEC && isWrite && inConv && s_reg.convLock)
      |=> s_reg.regs == $past(s_reg.regs);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked block was written");

  property p_reserved;
    (conversionConfig[7:6] == 2'b00) && (referenceConfig[7:5] == 3'b000)
      && !ampInputGainConfig[7];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  c_read:    cover property (rspValid && isRead && inConv);
  c_restart: cover property (conversionRestart);
  c_locked:  cover property (s_reg.phase == arb_pkg::PH_EXEC && isWrite && s_reg.convLock);

endmodule : arb_register_bank

// ===== tb/arb_host_model.sv
// Purpose: Host side issuing one register command at a time
// Assumes: Drives on falling edges, holds until taken
// Notes: Released command lines carry inverted data
`timescale 1ns/1ps
module arb_host_model (
  // Clock and answer
  input  wire logic       clk,
  input  wire logic       cmdReady,
  input  wire logic       rspValid,
  input  wire logic [7:0] rspData,
  // Selects and command
  output logic            converterSelectN,
  output logic            amplifierSelectN,
  output logic            cmdValid,
  output logic [7:0]      cmdOpcode,
  output logic [7:0]      cmdData,
  output logic            cmdCrcError,
  output logic            hung
);
  initial {converterSelectN, amplifierSelectN, cmdValid, cmdOpcode, cmdData} = 19'h6_0000;
  initial {cmdCrcError, hung} = 2'b00;

  task automatic xfer(input bit amp, input logic [7:0] op, d, input logic crc,
                      output logic [7:0] rd);
    int n;
    @(negedge clk);
    converterSelectN = amp;
    amplifierSelectN = !amp;
    // Selects pass two sync flops before the command may rely on them
    repeat (3) @(negedge clk);
    {cmdValid, cmdOpcode, cmdData, cmdCrcError} = {1'b1, op, d, crc};
    for (n = 0; n < 20 && cmdReady !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    {cmdValid, cmdOpcode, cmdData, cmdCrcError} = {1'b0, ~op, ~d, 1'b0};
    for (n = 0; n < 20 && rspValid !== 1'b1; n++) @(negedge clk);
    if (n == 20) hung = 1'b1;
    rd = rspData;
    {converterSelectN, amplifierSelectN} = 2'b11;
  endtask : xfer
endmodule : arb_host_model

// ===== tb/arb_register_bank_bench.sv
// Purpose: Self-checking bench of the register bank
// Assumes: Partner model speaks the command port
// Notes: Expected values come from the register map
`timescale 1ns/1ps
module arb_register_bank_bench;
  logic clk = 0, reset = 1, resultReady = 0, resultRead = 0, cycleStart = 0;
  logic referenceLow = 0, externalClock = 0, hung;
  logic [7:0] ampAlarm = 8'h00, rdv;
  logic converterSelectN, amplifierSelectN, cmdValid, cmdCrcError, cmdReady, rspValid;
  logic conversionRestart, aggregateErrorFlag, converterLockFlag, amplifierLockFlag;
  logic [7:0] cmdOpcode, cmdData, rspData, rateFilterConfig, conversionConfig;
  logic [7:0] referenceConfig, gpioSetup;
  int errTotal = 0, checksDone = 0, restarts = 0, n0;
  localparam logic [7:0] DFLT [0:15] = '{8'h51, 8'h01, 8'h24, 8'h01, 8'h00, 8'h00,
    8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'hFF, 8'h00, 8'h00};

  always #2 clk = ~clk;
  always @(posedge clk) if (conversionRestart === 1'b1) restarts++;

  arb_host_model host (.clk, .cmdReady, .rspValid, .rspData, .converterSelectN,
    .amplifierSelectN, .cmdValid, .cmdOpcode, .cmdData, .cmdCrcError, .hung);

  arb_register_bank dut (.clk, .reset, .converterSelectN, .amplifierSelectN,
    .cmdValid, .cmdReady, .cmdOpcode, .cmdData, .cmdCrcError, .rspValid, .rspData,
    .resultReady, .resultRead, .cycleStart, .referenceLow, .externalClock,
    .ampAlarm, .rateFilterConfig, .conversionConfig, .gpioSetup,
    .gpioLevelStatusEnable(), .referenceConfig, .offsetCal(), .gainCal(),
    .excitationRoute(), .excitationLevel(), .ampInputGainConfig(),
    .conversionRestart, .converterLockFlag, .amplifierLockFlag,
    .aggregateErrorFlag);

  task automatic report_and_stop();
    if (errTotal == 0 && checksDone > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checksDone++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic op(input bit amp, input logic [7:0] c, d, input logic crc = 1'b0);
    host.xfer(amp, c, d, crc, rdv);
    if (hung === 1'b1)
    begin
      errTotal++;
      report_and_stop();
    end
  endtask : op

  task automatic rd(input bit amp, input logic [4:0] a, input logic [7:0] exp);
    op(amp, {3'h1, a}, 8'h00);
    chk($sformatf("register %h", a), rdv, exp);
  endtask : rd

  initial
  begin
    repeat (20) @(negedge clk);
    reset = 0;
    for (int a = 0; a < 16; a++)
      rd(0, 5'(a), DFLT[a]);
    rd(1, 5'h10, 8'h50);
    rd(1, 5'h12, 8'h02);
    rd(0, 5'h10, 8'h00);
    rd(1, 5'h02, 8'h00);
    rd(0, 5'h13, 8'h00);
    op(0, 8'h41, 8'h00);
    rd(0, 5'h01, 8'h00);
    op(0, 8'h40, 8'h00);
    rd(0, 5'h00, 8'h51);
    op(0, 8'h43, 8'hFF);
    rd(0, 5'h03, 8'h3F);
    chk("conversionConfig", conversionConfig, 8'h3F);
    n0 = restarts;
    op(0, 8'h42, 8'h55);
    op(0, 8'h42, 8'h55);
    op(0, 8'h46, 8'h1F);
    op(0, 8'h44, 8'h3C);
    chk("restarts", 8'(restarts - n0), 8'h02);
    chk("rateFilterConfig", rateFilterConfig, 8'h55);
    chk("referenceConfig", referenceConfig, 8'h1F);
    chk("gpioSetup", gpioSetup, 8'h3C);
    op(0, 8'hF2, 8'h00);
    op(0, 8'h42, 8'h11);
    rd(0, 5'h02, 8'h55);
    rd(0, 5'h01, 8'h80);
    chk("converterLockFlag", {7'h00, converterLockFlag}, 8'h01);
    op(0, 8'hF5, 8'h00);
    op(0, 8'h42, 8'h77, 1'b1);
    rd(0, 5'h02, 8'h55);
    rd(0, 5'h01, 8'h40);
    op(0, 8'h41, 8'hBF);
    rd(0, 5'h01, 8'h00);
    op(1, 8'h50, 8'h00, 1'b1);
    rd(1, 5'h12, 8'h12);
    rd(0, 5'h01, 8'h10);
    op(1, 8'h52, 8'h02);
    rd(0, 5'h01, 8'h00);
    @(negedge clk);
    {externalClock, referenceLow, ampAlarm[3], resultReady} = 4'hF;
    @(negedge clk);
    {resultReady, referenceLow, ampAlarm} = 10'h000;
    chk("aggregateErrorFlag", {7'h00, aggregateErrorFlag}, 8'h01);
    rd(0, 5'h01, 8'h1E);
    rd(1, 5'h11, 8'h08);
    {cycleStart, resultRead} = 2'b11;
    @(negedge clk);
    {cycleStart, resultRead, externalClock} = 3'b000;
    rd(0, 5'h01, 8'h00);
    op(1, 8'hF2, 8'h00);
    op(1, 8'h50, 8'h33);
    rd(1, 5'h10, 8'h50);
    rd(1, 5'h12, 8'h22);
    chk("amplifierLockFlag", {7'h00, amplifierLockFlag}, 8'h01);
    n0 = restarts;
    op(0, 8'h06, 8'h00);
    rd(0, 5'h01, 8'h01);
    rd(0, 5'h02, 8'h24);
    chk("restarts", 8'(restarts - n0), 8'h01);
    chk("conversionConfig", conversionConfig, 8'h01);
    chk("amplifierLockFlag", {7'h00, amplifierLockFlag}, 8'h00);
    report_and_stop();
  end
endmodule : arb_register_bank_bench
